// [rtl/ctp_pkg.sv]
// package: register map, field layout, reset values and codes of the capture timer
package ctp_pkg;

    // register byte addresses
    localparam logic [31:0] OFS_RELOAD = 32'hffff_0320;
    localparam logic [31:0] OFS_VALUE = 32'hffff_0324;
    localparam logic [31:0] OFS_CONTROL = 32'hffff_0328;
    localparam logic [31:0] OFS_CLEAR = 32'hffff_032c;
    localparam logic [31:0] OFS_CAPTURE = 32'hffff_0330;
    localparam logic [31:0] OFS_IRQ_STATUS = 32'hffff_0334;
    localparam logic [31:0] OFS_IRQ_MASK = 32'hffff_0338;

    // control field positions
    localparam int CTL_PS_LSB = 24;
    localparam int CTL_PS_EN = 23;
    localparam int CTL_ISRC = 18;
    localparam int CTL_CAP_EN = 17;
    localparam int CTL_EVT_LSB = 12;
    localparam int CTL_CLK_LSB = 9;
    localparam int CTL_UP = 8;
    localparam int CTL_EN = 7;
    localparam int CTL_PERIODIC = 6;
    localparam int CTL_FMT_LSB = 4;
    localparam int CTL_PRE_LSB = 0;

    // reset values
    localparam logic [31:0] RST_RELOAD = 32'h0000_0000;
    localparam logic [31:0] RST_VALUE = 32'hffff_ffff;
    localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
    localparam logic [7:0] RST_PS_TC = 8'h01;
    localparam logic [1:0] RST_MASK = 2'h0;

    // count source codes
    typedef enum logic [2:0] {
        CTP_CLK_CORE = 3'b000,
        CTP_CLK_LPOSC = 3'b001,
        CTP_CLK_PIN_A = 3'b010,
        CTP_CLK_PIN_B = 3'b011
    } ctp_clk_e;

    // count encodings
    typedef enum logic [1:0] {
        CTP_FMT_BIN = 2'b00,
        CTP_FMT_RSVD = 2'b01,
        CTP_FMT_HMS23 = 2'b10,
        CTP_FMT_HMS255 = 2'b11
    } ctp_fmt_e;

    // prescaler codes and divider terminal counts
    localparam logic [3:0] PRE_DIV16 = 4'h4;
    localparam logic [3:0] PRE_DIV256 = 4'h8;
    localparam logic [7:0] PRE_LIM1 = 8'h00;
    localparam logic [7:0] PRE_LIM16 = 8'h0f;
    localparam logic [7:0] PRE_LIM256 = 8'hff;

    // clock-of-day field limits and binary count maximum
    localparam logic [7:0] HMS_HUND_MAX = 8'h63;
    localparam logic [7:0] HMS_SEC_MAX = 8'h3b;
    localparam logic [7:0] HMS_MIN_MAX = 8'h3b;
    localparam logic [7:0] HMS_HR23_MAX = 8'h17;
    localparam logic [7:0] HMS_HR255_MAX = 8'hff;
    localparam logic [31:0] BIN_MAX = 32'hffff_ffff;

    // interrupt status bits
    localparam int STS_TIMEOUT = 0;
    localparam int STS_CAPTURE = 1;

endpackage

// [rtl/ctp_pin_sync.sv]
// two-flop synchroniser with rising-edge pulse for one outside pin
module ctp_pin_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pin and synchronised results
    input wire logic pin_async,
    output logic level,
    output logic rise
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // meta_q feeds only sync_q
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // level and one-cycle rise pulse from settled flops
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;

endmodule

// [rtl/ctp_timer.sv]
// main module: 32-bit capture timer with prescaler, post-scaler and register port
//
// The address-and-strobe port was decided locally.

// Functional notes
// - read-only capture register holds latched count
// - post-scaler field: zero means one, reads count
// - post-scaler enabled: interrupt after programmed timeouts
// - compare flag sets when timeouts reach terminal
// - source bit picks post-scaler or direct timeout
// - capture enable bit gates event capture
// - five-bit field selects one of 32 sources
// - clock select: core, oscillator, pin a, b
// - direction bit: up when set, down default
// - enable bit starts counter, off after reset
// - mode bit: periodic reload, else free-running
// - format: binary or clock-of-day, 23/255 hours
// - prescaler divides by 1, 16 or 256
// - periodic reload on overflow, reload on clear write
// - clear write drops pending timer interrupt
// - first source assertion copies count, keeps running
// - low power: pin or oscillator sources keep counting
module ctp_timer #(
    parameter int EVT_N = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // count sources and power state, asynchronous
    input wire logic lp_osc_clk,
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    input wire logic low_power_mode,
    // interrupt sources for capture, same clock
    input wire logic [EVT_N-1:0] irq_sources,
    // interrupt output
    output logic timer_irq
);

    logic [31:0] reload_q;
    logic [31:0] count_q;
    logic [31:0] capture_q;
    logic [31:0] rdata_q;
    logic [7:0] ps_tc_q;
    logic [7:0] ps_cnt_q;
    logic [7:0] div_q;
    logic ps_en_q;
    logic isrc_q;
    logic cap_en_q;
    logic up_q;
    logic en_q;
    logic periodic_q;
    logic cmp_q;
    logic [4:0] evt_sel_q;
    logic [2:0] clk_sel_q;
    logic [1:0] fmt_q;
    logic [3:0] pre_q;
    logic [1:0] sts_q;
    logic [1:0] mask_q;
    logic [EVT_N-1:0] src_prev_q;
    logic wr_reload;
    logic wr_control;
    logic wr_clear;
    logic wr_status;
    logic wr_mask;
    logic [3:0] pin_raw;
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic src_tick;
    logic [7:0] div_lim;
    logic core_hold;
    logic run;
    logic presc_tick;
    logic is_hms;
    logic [7:0] hr_max;
    logic [31:0] top;
    logic at_end;
    logic [31:0] step;
    logic timeout;
    logic [7:0] ps_inc;
    logic ps_hit;
    logic timer_evt;
    logic src_rise;
    logic cap_evt;
    logic [7:0] ps_wr;
    logic [31:0] rd_mux;

    // one step of the clock-of-day count with carry or borrow between fields
    function automatic logic [31:0] hms_step(input logic [31:0] v, input logic up,
                                             input logic [7:0] hr);
        logic [31:0] r;
        logic carry;
        logic [7:0] f;
        logic [7:0] lim;
        begin
            r = v;
            carry = 1'b1;
            for (int i = 0; i < 4; i++) begin
                f = v[i*8 +: 8];
                case (i)
                    0: lim = ctp_pkg::HMS_HUND_MAX;
                    1: lim = ctp_pkg::HMS_SEC_MAX;
                    2: lim = ctp_pkg::HMS_MIN_MAX;
                    default: lim = hr;
                endcase
                if (carry) begin
                    if (up) begin
                        if (f >= lim) begin
                            r[i*8 +: 8] = 8'h00;
                        end else begin
                            r[i*8 +: 8] = f + 8'h01;
                            carry = 1'b0;
                        end
                    end else begin
                        if (f == 8'h00) begin
                            r[i*8 +: 8] = lim;
                        end else begin
                            r[i*8 +: 8] = f - 8'h01;
                            carry = 1'b0;
                        end
                    end
                end
            end
            return r;
        end
    endfunction

    // write decode
    assign wr_reload = reg_wr && (reg_addr == ctp_pkg::OFS_RELOAD);
    assign wr_control = reg_wr && (reg_addr == ctp_pkg::OFS_CONTROL);
    assign wr_clear = reg_wr && (reg_addr == ctp_pkg::OFS_CLEAR);
    assign wr_status = reg_wr && (reg_addr == ctp_pkg::OFS_IRQ_STATUS);
    assign wr_mask = reg_wr && (reg_addr == ctp_pkg::OFS_IRQ_MASK);

    // synchronise oscillator, both pins and the power state
    assign pin_raw = {low_power_mode, ext_pin_b, ext_pin_a, lp_osc_clk};
    for (genvar gi = 0; gi < 4; gi++) begin : g_sync
        ctp_pin_sync u_sync (
            .mclk(mclk),
            .rst(rst),
            .pin_async(pin_raw[gi]),
            .level(pin_lvl[gi]),
            .rise(pin_rise[gi])
        );
    end

    // count source select
    always_comb begin
        case (clk_sel_q)
            ctp_pkg::CTP_CLK_CORE: src_tick = 1'b1;
            ctp_pkg::CTP_CLK_LPOSC: src_tick = pin_rise[0];
            ctp_pkg::CTP_CLK_PIN_A: src_tick = pin_rise[1];
            ctp_pkg::CTP_CLK_PIN_B: src_tick = pin_rise[2];
            default: src_tick = 1'b0;
        endcase
    end

    // prescaler terminal count, reserved codes divide by one
    always_comb begin
        case (pre_q)
            ctp_pkg::PRE_DIV16: div_lim = ctp_pkg::PRE_LIM16;
            ctp_pkg::PRE_DIV256: div_lim = ctp_pkg::PRE_LIM256;
            default: div_lim = ctp_pkg::PRE_LIM1;
        endcase
    end

    // core clock stops in low power; pin and oscillator sources run on
    assign core_hold = pin_lvl[3] && (clk_sel_q == ctp_pkg::CTP_CLK_CORE);
    assign run = en_q && !core_hold;
    assign presc_tick = run && src_tick && (div_q == div_lim);

    // prescaler divider
    always_ff @(posedge mclk) begin
        if (rst || wr_clear || !en_q) begin
            div_q <= 8'h00;
        end else if (run && src_tick) begin
            div_q <= (div_q >= div_lim) ? 8'h00 : div_q + 8'h01;
        end
    end

    // end of range and next value for the selected format
    assign is_hms = fmt_q[1];
    assign hr_max = (fmt_q == ctp_pkg::CTP_FMT_HMS255) ? ctp_pkg::HMS_HR255_MAX
                                                       : ctp_pkg::HMS_HR23_MAX;
    assign top = is_hms ? {hr_max, ctp_pkg::HMS_MIN_MAX, ctp_pkg::HMS_SEC_MAX,
                           ctp_pkg::HMS_HUND_MAX} : ctp_pkg::BIN_MAX;
    assign at_end = up_q ? (count_q == top) : (count_q == 32'h0000_0000);
    assign step = is_hms ? hms_step(count_q, up_q, hr_max)
                         : (up_q ? count_q + 32'h0000_0001 : count_q - 32'h0000_0001);
    assign timeout = presc_tick && at_end && !wr_clear;

    // main counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q <= ctp_pkg::RST_VALUE;
        end else if (wr_clear) begin
            count_q <= reload_q;
        end else if (presc_tick) begin
            if (at_end) begin
                count_q <= periodic_q ? reload_q : (up_q ? 32'h0000_0000 : top);
            end else begin
                count_q <= step;
            end
        end
    end

    // post-scaler counts timeouts up to the terminal count
    assign ps_inc = ps_cnt_q + 8'h01;
    assign ps_hit = timeout && ps_en_q && (ps_inc == ps_tc_q);
    always_ff @(posedge mclk) begin
        if (rst || !ps_en_q || wr_clear) begin
            ps_cnt_q <= 8'h00;
        end else if (timeout) begin
            ps_cnt_q <= ps_hit ? 8'h00 : ps_inc;
        end
    end

    // compare flag, the clear strobe wins over a terminal timeout in its cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmp_q <= 1'b0;
        end else if (ps_hit) begin
            cmp_q <= 1'b1;
        end else if (wr_clear) begin
            cmp_q <= 1'b0;
        end
    end

    // interrupt event route
    assign timer_evt = isrc_q ? ps_hit : timeout;

    // capture on the first assertion of the selected source
    assign src_rise = irq_sources[evt_sel_q] && !src_prev_q[evt_sel_q];
    assign cap_evt = cap_en_q && src_rise;
    always_ff @(posedge mclk) begin
        if (rst) begin
            src_prev_q <= '0;
            capture_q <= ctp_pkg::RST_CAPTURE;
        end else begin
            src_prev_q <= irq_sources;
            if (cap_evt) begin
                capture_q <= count_q;
            end
        end
    end

    // sticky status, set wins over write-one-to-clear; the clear strobe always drops the timeout bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            sts_q <= 2'b00;
        end else begin
            sts_q[ctp_pkg::STS_TIMEOUT] <= timer_evt || (sts_q[ctp_pkg::STS_TIMEOUT]
                && !wr_clear && !(wr_status && reg_wdata[ctp_pkg::STS_TIMEOUT]));
            sts_q[ctp_pkg::STS_CAPTURE] <= cap_evt || (sts_q[ctp_pkg::STS_CAPTURE]
                && !(wr_status && reg_wdata[ctp_pkg::STS_CAPTURE]));
        end
    end
    assign timer_irq = |(sts_q & mask_q);

    // software-owned registers; reserved bits 22-20 and flag bit 19 are not stored
    assign ps_wr = reg_wdata[ctp_pkg::CTL_PS_LSB +: 8];
    always_ff @(posedge mclk) begin
        if (rst) begin
            reload_q <= ctp_pkg::RST_RELOAD;
            mask_q <= ctp_pkg::RST_MASK;
            ps_tc_q <= ctp_pkg::RST_PS_TC;
            {ps_en_q, isrc_q, cap_en_q, up_q, en_q, periodic_q} <= 6'b00_0000;
            evt_sel_q <= 5'h00;
            clk_sel_q <= 3'h0;
            fmt_q <= 2'h0;
            pre_q <= 4'h0;
        end else begin
            if (wr_reload) begin
                reload_q <= reg_wdata;
            end
            if (wr_mask) begin
                mask_q <= reg_wdata[1:0];
            end
            if (wr_control) begin
                ps_tc_q <= (ps_wr == 8'h00) ? 8'h01 : ps_wr;
                ps_en_q <= reg_wdata[ctp_pkg::CTL_PS_EN];
                isrc_q <= reg_wdata[ctp_pkg::CTL_ISRC];
                cap_en_q <= reg_wdata[ctp_pkg::CTL_CAP_EN];
                evt_sel_q <= reg_wdata[ctp_pkg::CTL_EVT_LSB +: 5];
                clk_sel_q <= reg_wdata[ctp_pkg::CTL_CLK_LSB +: 3];
                up_q <= reg_wdata[ctp_pkg::CTL_UP];
                en_q <= reg_wdata[ctp_pkg::CTL_EN];
                periodic_q <= reg_wdata[ctp_pkg::CTL_PERIODIC];
                fmt_q <= reg_wdata[ctp_pkg::CTL_FMT_LSB +: 2];
                pre_q <= reg_wdata[ctp_pkg::CTL_PRE_LSB +: 4];
            end
        end
    end

    // read mux; clear register and unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            ctp_pkg::OFS_RELOAD: rd_mux = reload_q;
            ctp_pkg::OFS_VALUE: rd_mux = count_q;
            ctp_pkg::OFS_CONTROL: rd_mux = {ps_cnt_q, ps_en_q, 3'b000, cmp_q, isrc_q, cap_en_q,
                evt_sel_q, clk_sel_q, up_q, en_q, periodic_q, fmt_q, pre_q};
            ctp_pkg::OFS_CAPTURE: rd_mux = capture_q;
            ctp_pkg::OFS_IRQ_STATUS: rd_mux = {30'h0000_0000, sts_q};
            ctp_pkg::OFS_IRQ_MASK: rd_mux = {30'h0000_0000, mask_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stand for exactly one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_q;

    // checks on the timer behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence cap_trig_s;
        cap_en_q && src_rise;
    endsequence

    sequence ps_wr_zero_s;
        wr_control && (reg_wdata[31:24] == 8'h00);
    endsequence

    cap_latch_a: assert property (cap_trig_s |=> (capture_q == $past(count_q))
        && sts_q[1]) else $error("capture did not latch count");
    cap_gate_a: assert property (!cap_evt |=> $stable(capture_q))
        else $error("capture changed without enabled event");
    ps_zero_a: assert property (ps_wr_zero_s |=> ps_tc_q == 8'h01)
        else $error("post-scaler zero not taken as one");
    ps_read_a: assert property (reg_rd && reg_addr == ctp_pkg::OFS_CONTROL
        |=> reg_rdata[31:24] == $past(ps_cnt_q))
        else $error("post-scaler count not returned");
    cmp_set_a: assert property (ps_hit |=> cmp_q && ps_cnt_q == 8'h00)
        else $error("compare flag not set on terminal count");
    hold_off_a: assert property (!en_q && !wr_clear |=> $stable(count_q))
        else $error("counter moved while disabled");
    clr_reload_a: assert property (wr_clear |=> count_q == $past(reload_q))
        else $error("clear strobe did not reload");
    irq_clear_a: assert property (wr_clear && !timer_evt |=> !sts_q[0])
        else $error("clear strobe kept timer interrupt");
    irq_hold_a: assert property (sts_q[0] && !wr_clear && !(wr_status && reg_wdata[0])
        |=> sts_q[0]) else $error("timer interrupt dropped by itself");
    count_up_a: assert property (presc_tick && up_q && fmt_q == 2'b00 && !at_end && !wr_clear
        |=> count_q == $past(count_q) + 32'h0000_0001)
        else $error("binary up count wrong");
    periodic_a: assert property (timeout && periodic_q |=> count_q == $past(reload_q))
        else $error("periodic mode did not reload");
    hms_wrap_a: assert property (presc_tick && is_hms && up_q && !at_end && !wr_clear
        && count_q[7:0] == 8'h63 |=> count_q[7:0] == 8'h00)
        else $error("hundredths did not wrap");
    lp_hold_a: assert property (core_hold && !wr_clear [*2] |-> $stable(count_q))
        else $error("core-clocked count ran in low power");

endmodule

// [tb/ctp_timer_test.sv]
// self-checking bench of the capture timer: registers, counting, capture and interrupts
module ctp_timer_test;
    timeunit 1ns;
    timeprecision 1ns;

    // control bit masks and run limit
    localparam logic [31:0] EN = 32'h0000_0080;
    localparam logic [31:0] UP = 32'h0000_0100;
    localparam logic [31:0] PER = 32'h0000_0040;
    localparam logic [31:0] ISRC = 32'h0004_0000;
    localparam logic [31:0] PSE = 32'h0080_0000;
    localparam logic [31:0] CAP = 32'h0002_0000;
    localparam logic [31:0] EVT31 = 32'h0001_f000;
    localparam int LIMIT = 20000;

    // design ports
    logic mclk;
    logic rst;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic lp_osc_clk;
    logic ext_pin_a;
    logic ext_pin_b;
    logic low_power_mode;
    logic [31:0] irq_sources;
    logic timer_irq;

    // bookkeeping and tables
    int fail_count;
    int n_compared;
    int cycles = 0;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] rs_adr [8] = '{ctp_pkg::OFS_VALUE, ctp_pkg::OFS_RELOAD, ctp_pkg::OFS_CONTROL,
        ctp_pkg::OFS_CAPTURE, ctp_pkg::OFS_IRQ_STATUS, ctp_pkg::OFS_IRQ_MASK,
        ctp_pkg::OFS_CLEAR, 32'hffff_0300};
    logic [31:0] rs_exp [8] = '{32'hffff_ffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [3:0] pre_code [4] = '{4'h0, ctp_pkg::PRE_DIV16, ctp_pkg::PRE_DIV256, 4'h2};
    int pre_div [4] = '{1, 16, 256, 1};
    logic [31:0] h_start [5] = '{32'h173b_3b63, 32'h173b_3b63, 32'h0100_0000, 32'h173b_3b63,
        32'h0000_0100};
    logic [31:0] h_ctl [5] = '{32'h0000_05a0, 32'h0000_05b0, 32'h0000_04b0, 32'h0000_0580,
        32'h0000_0490};
    int h_n [5] = '{2, 1, 2, 1, 1};
    logic [31:0] h_exp [5] = '{32'h0000_0001, 32'h1800_0000, 32'h003b_3b62, 32'h173b_3b64,
        32'h0000_00ff};

    ctp_timer #(.EVT_N(32)) i_dut (
        .mclk(mclk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .lp_osc_clk(lp_osc_clk),
        .ext_pin_a(ext_pin_a),
        .ext_pin_b(ext_pin_b),
        .low_power_mode(low_power_mode),
        .irq_sources(irq_sources),
        .timer_irq(timer_irq)
    );

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle write strobe, then step past the edge so its effect has landed
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wait_irq(input int n);
        for (int k = 0; k < n && timer_irq !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
    endtask

    // rising edges on the oscillator and pin inputs, slow enough for the synchronisers
    task automatic pulse(input logic [2:0] which, input int n);
        repeat (n) begin
            @(posedge mclk);
            {ext_pin_b, ext_pin_a, lp_osc_clk} <= which;
            repeat (4) @(posedge mclk);
            {ext_pin_b, ext_pin_a, lp_osc_clk} <= 3'b000;
            repeat (3) @(posedge mclk);
        end
    endtask

    task automatic src(input logic [31:0] s);
        @(posedge mclk);
        irq_sources <= s;
        idle(2);
    endtask

    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        {rst, reg_wr, reg_rd, lp_osc_clk, ext_pin_a, ext_pin_b, low_power_mode} = 7'h40;
        reg_addr = '0;
        reg_wdata = '0;
        irq_sources = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        // reset values, unmapped and write-only reads
        for (int i = 0; i < 8; i++) begin
            rd(rs_adr[i], v1);
            check("reset read", v1, rs_exp[i]);
        end
        check("irq after reset", 32'(timer_irq), 32'h0);
        // read-only places ignore writes, clear write reloads
        wr(ctp_pkg::OFS_RELOAD, 32'h1234_5678);
        wr(ctp_pkg::OFS_VALUE, 32'h0000_0000);
        wr(ctp_pkg::OFS_CAPTURE, 32'h0000_00aa);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        rd(ctp_pkg::OFS_VALUE, v1);
        check("value after clear", v1, 32'h1234_5678);
        rd(ctp_pkg::OFS_CAPTURE, v1);
        check("capture read-only", v1, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, 32'h0008_0000);
        rd(ctp_pkg::OFS_CONTROL, v1);
        check("control reserved", v1, 32'h0000_0000);
        // core clock down count through each divide ratio and one reserved code
        wr(ctp_pkg::OFS_RELOAD, 32'h1000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
            wr(ctp_pkg::OFS_CONTROL, EN | 32'(pre_code[i]));
            rd(ctp_pkg::OFS_VALUE, v1);
            idle(2 * pre_div[i] - 2);
            rd(ctp_pkg::OFS_VALUE, v2);
            check("prescaled step", v1 - v2, 32'h0000_0002);
        end
        wr(ctp_pkg::OFS_CONTROL, EN | UP);
        rd(ctp_pkg::OFS_VALUE, v1);
        rd(ctp_pkg::OFS_VALUE, v2);
        check("up step", v2 - v1, 32'h0000_0002);
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        rd(ctp_pkg::OFS_VALUE, v1);
        rd(ctp_pkg::OFS_VALUE, v2);
        check("stopped step", v2 - v1, 32'h0000_0000);
        // low power: core source stops, oscillator and pins keep counting
        @(posedge mclk) low_power_mode <= 1'b1;
        wr(ctp_pkg::OFS_CONTROL, EN);
        idle(4);
        rd(ctp_pkg::OFS_VALUE, v1);
        rd(ctp_pkg::OFS_VALUE, v2);
        check("core in low power", v2 - v1, 32'h0000_0000);
        wr(ctp_pkg::OFS_RELOAD, 32'h0000_0000);
        for (int s = 1; s < 4; s++) begin
            wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
            wr(ctp_pkg::OFS_CONTROL, EN | UP | (32'(s) << 9));
            pulse(3'b001, 2);
            pulse(3'b010, 3);
            pulse(3'b100, 4);
            idle(4);
            rd(ctp_pkg::OFS_VALUE, v1);
            check("source select", v1, 32'(s + 1));
        end
        @(posedge mclk) low_power_mode <= 1'b0;
        // count encodings, stepped by pin a edges
        for (int i = 0; i < 5; i++) begin
            wr(ctp_pkg::OFS_RELOAD, h_start[i]);
            wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
            wr(ctp_pkg::OFS_CONTROL, h_ctl[i]);
            pulse(3'b010, h_n[i]);
            idle(4);
            rd(ctp_pkg::OFS_VALUE, v1);
            check("format count", v1, h_exp[i]);
        end
        // direct timeout, free-running wrap, mask and sticky status
        wr(ctp_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
        wr(ctp_pkg::OFS_RELOAD, 32'h0000_0003);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, EN);
        v1 = '0;
        for (int k = 0; k < 20 && v1[0] !== 1'b1; k++) begin
            rd(ctp_pkg::OFS_IRQ_STATUS, v1);
        end
        check("timeout status", v1, 32'h0000_0001);
        check("masked irq", 32'(timer_irq), 32'h0);
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        rd(ctp_pkg::OFS_VALUE, v1);
        check("free-run wrap", v1 & 32'hffff_ff00, 32'hffff_ff00);
        wr(ctp_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        check("unmasked irq", 32'(timer_irq), 32'h1);
        idle(10);
        check("irq held", 32'(timer_irq), 32'h1);
        wr(ctp_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        check("irq after w1c", 32'(timer_irq), 32'h0);
        // periodic reload, cleared through the clear register
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, EN | PER);
        wait_irq(20);
        check("periodic irq", 32'(timer_irq), 32'h1);
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        rd(ctp_pkg::OFS_VALUE, v1);
        check("periodic value", v1 & 32'hffff_fffc, 32'h0000_0000);
        idle(10);
        check("irq held", 32'(timer_irq), 32'h1);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_00a5);
        check("irq after clear", 32'(timer_irq), 32'h0);
        // post-scaler: three timeouts of 21 cycles before the interrupt
        wr(ctp_pkg::OFS_RELOAD, 32'h0000_0014);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, 32'h0300_0000 | PSE | ISRC | EN | PER);
        idle(30);
        rd(ctp_pkg::OFS_CONTROL, v1);
        check("post count", v1 & 32'hff08_0000, 32'h0100_0000);
        check("post early irq", 32'(timer_irq), 32'h0);
        wait_irq(60);
        check("post irq", 32'(timer_irq), 32'h1);
        rd(ctp_pkg::OFS_CONTROL, v1);
        check("compare flag", v1 & 32'hff08_0000, 32'h0008_0000);
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, PSE | ISRC | EN | PER);
        wait_irq(30);
        check("terminal zero", 32'(timer_irq), 32'h1);
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, ISRC | EN | PER);
        idle(60);
        check("post disabled", 32'(timer_irq), 32'h0);
        // capture on source 31 only, first assertion only, gated by enable
        wr(ctp_pkg::OFS_CONTROL, 32'h0000_0000);
        wr(ctp_pkg::OFS_RELOAD, 32'h0000_0055);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, CAP | EVT31);
        src(32'h0000_0001);
        src(32'h0000_0000);
        rd(ctp_pkg::OFS_CAPTURE, v1);
        check("other source", v1, 32'h0000_0000);
        src(32'h8000_0000);
        rd(ctp_pkg::OFS_CAPTURE, v1);
        check("captured", v1, 32'h0000_0055);
        rd(ctp_pkg::OFS_IRQ_STATUS, v1);
        check("capture status", v1, 32'h0000_0002);
        wr(ctp_pkg::OFS_RELOAD, 32'h0000_0066);
        wr(ctp_pkg::OFS_CLEAR, 32'h0000_0000);
        idle(3);
        rd(ctp_pkg::OFS_CAPTURE, v1);
        check("held source", v1, 32'h0000_0055);
        src(32'h0000_0000);
        wr(ctp_pkg::OFS_CONTROL, EVT31);
        src(32'h8000_0000);
        rd(ctp_pkg::OFS_CAPTURE, v1);
        check("capture off", v1, 32'h0000_0055);
        wr(ctp_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        check("capture irq", 32'(timer_irq), 32'h1);
        wr(ctp_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        check("capture irq w1c", 32'(timer_irq), 32'h0);
        end_of_test();
    end
endmodule
